// ---- rtl/reset_period_state_control.sv ----
`timescale 1ns/1ps
`include "reset_period_defs.svh"

// Operation
// - while reset, core clock gated and both internal oscillators stopped
// - during reset crystal stopped, both oscillator pins become plain inputs
// - during reset external main clock ignored, its pin acts as input
// - during reset memories and peripherals stopped; supply detector keeps running
// - pull-up pin floats on pin or retention reset, else pulled high
// - reset-shared pin reads low while external reset held low
// - reset-shared pin pulled high on internal resets and after release
// - program counter loaded from two-byte vector at lowest two addresses
// - status word preset after reset; stack, RAM, registers left untouched
// - during reset and wait only the program counter is undefined
// - other port pins high-impedance during and after reset
// - reset follows pin low; run starts on fast internal oscillator
module reset_period_state_control
    import reset_period_pkg::*;
#(
    parameter int PC_WIDTH   = 20,
    parameter int PORT_COUNT = 8
)
(
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    input  wire logic                  i_ext_reset_n,
    input  wire logic                  i_wdt_reset,
    input  wire logic                  i_illegal_instr_reset,
    input  wire logic                  i_illegal_access_reset,
    input  wire logic                  i_supply_reset,
    input  wire logic                  i_retention_reset,
    input  wire logic [7:0]            i_mem_rdata,
    output logic [PC_WIDTH-1:0]        o_mem_addr,
    output logic                       o_mem_read,
    output logic                       o_internal_reset,
    output logic                       o_cpu_clk_en,
    output logic                       o_fast_internal_osc_en,
    output logic                       o_slow_internal_osc_en,
    output logic                       o_crystal_osc_en,
    output logic                       o_osc_pins_input_mode,
    output logic                       o_external_main_clk_valid,
    output logic                       o_periph_run,
    output logic                       o_supply_detect_en,
    output logic                       o_pullup_port_pin_pullup_en,
    output logic                       o_pullup_port_pin_oe_n,
    output logic                       o_reset_shared_pin_pullup_en,
    output logic                       o_reset_shared_pin_oe_n,
    output logic [PORT_COUNT-1:0]      o_port_oe_n,
    output logic                       o_pc_valid,
    output logic [PC_WIDTH-1:0]        o_pc,
    output logic [7:0]                 o_program_status_word,
    output logic                       o_cpu_start
);

    // ------------------------------------------------------------
    // source synchronisation
    // ------------------------------------------------------------
    localparam int SRC_N = 6;

    logic [SRC_N-1:0] src_raw;
    logic [SRC_N-1:0] src_lvl;

    sync_bus_if #(.WIDTH(SRC_N)) src_bus ();

    // pin is active low, all others active high
    assign src_raw = {i_retention_reset, i_supply_reset, i_illegal_access_reset,
                      i_illegal_instr_reset, i_wdt_reset, ~i_ext_reset_n};

    source_sync #(.WIDTH(SRC_N)) u_sync
    (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_async  (src_raw),
        .sync_out (src_bus)
    );

    assign src_lvl = src_bus.level;

    logic any_reset;
    logic ext_or_ret;

    // merged reset and the floating-pin class
    assign any_reset  = |src_lvl;
    assign ext_or_ret = src_lvl[0] | src_lvl[5];

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    seq_state_t          state_reg;
    seq_state_t          state_next;
    logic [7:0]          count_reg;
    logic [7:0]          count_next;
    logic [PC_WIDTH-1:0] pc_reg;
    logic [PC_WIDTH-1:0] pc_next;
    logic                pc_valid_reg;
    logic                pc_valid_next;
    logic [7:0]          psw_reg;
    logic [7:0]          psw_next;
    logic [PC_WIDTH-1:0] addr_reg;
    logic [PC_WIDTH-1:0] addr_next;
    logic                read_reg;
    logic                read_next;
    logic                start_reg;
    logic                start_next;

    // next state: hold in reset while any source, then vector fetch
    always_comb
    begin
        state_next    = state_reg;
        count_next    = count_reg;
        pc_next       = pc_reg;
        pc_valid_next = pc_valid_reg;
        psw_next      = psw_reg;
        addr_next     = addr_reg;
        read_next     = 1'b0;
        start_next    = 1'b0;
        if (any_reset)
        begin
            state_next    = ST_RESET;
            count_next    = 8'h00;
            pc_valid_next = 1'b0;
            psw_next      = `PSW_RESET_VALUE;
        end
        else
        begin
            case (state_reg)
                ST_RESET:
                begin
                    state_next = ST_PROCESS;
                    count_next = 8'h00;
                end
                ST_PROCESS:
                begin
                    count_next = count_reg + 8'h01;
                    if (count_reg == `RST_PROC_CYCLES - 8'h01)
                    begin
                        state_next = ST_VEC_LO;
                        addr_next  = PC_WIDTH'(`RST_VEC_ADDR_LO);
                        read_next  = 1'b1;
                    end
                end
                ST_VEC_LO:
                begin
                    state_next = ST_VEC_HI;
                    addr_next  = PC_WIDTH'(`RST_VEC_ADDR_HI);
                    read_next  = 1'b1;
                end
                ST_VEC_HI:
                begin
                    // low byte answered one cycle after its read
                    pc_next    = {{(PC_WIDTH-8){1'b0}}, i_mem_rdata};
                    state_next = ST_RUN;
                end
                ST_RUN:
                begin
                    if (!pc_valid_reg)
                    begin
                        pc_next       = {pc_reg[PC_WIDTH-1:16], i_mem_rdata, pc_reg[7:0]};
                        pc_valid_next = 1'b1;
                        start_next    = 1'b1;
                    end
                end
                default:
                begin
                    state_next = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg    <= ST_RESET;
            count_reg    <= 8'h00;
            pc_reg       <= '0;
            pc_valid_reg <= 1'b0;
            psw_reg      <= `PSW_RESET_VALUE;
            addr_reg     <= '0;
            read_reg     <= 1'b0;
            start_reg    <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            pc_reg       <= pc_next;
            pc_valid_reg <= pc_valid_next;
            psw_reg      <= psw_next;
            addr_reg     <= addr_next;
            read_reg     <= read_next;
            start_reg    <= start_next;
        end
    end

    // ------------------------------------------------------------
    // clock, oscillator, peripheral and pin controls
    // ------------------------------------------------------------
    logic                  in_reset;
    logic                  ctl_reset_reg;
    logic                  ctl_cpu_clk_reg;
    logic                  ctl_osc_reg;
    logic                  pull40_en_reg;
    logic                  pull40_en_next;
    logic                  oe40_n_reg;
    logic                  pull125_en_reg;
    logic                  pull125_en_next;
    logic                  ctl_reset_next;
    logic                  ctl_cpu_clk_next;
    logic                  ctl_osc_next;

    // only an active source or the ST_RESET state counts as reset period
    assign in_reset = any_reset | (state_reg == ST_RESET);

    // control next values
    always_comb
    begin
        ctl_reset_next   = in_reset;
        ctl_cpu_clk_next = ~any_reset & (state_next == ST_RUN) & pc_valid_next;
        ctl_osc_next     = ~any_reset;
        pull40_en_next   = ~(any_reset & ext_or_ret);
        pull125_en_next  = ~src_lvl[0];
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctl_reset_reg   <= 1'b1;
            ctl_cpu_clk_reg <= 1'b0;
            ctl_osc_reg     <= 1'b0;
            pull40_en_reg   <= 1'b0;
            oe40_n_reg      <= 1'b1;
            pull125_en_reg  <= 1'b0;
        end
        else
        begin
            ctl_reset_reg   <= ctl_reset_next;
            ctl_cpu_clk_reg <= ctl_cpu_clk_next;
            ctl_osc_reg     <= ctl_osc_next;
            pull40_en_reg   <= pull40_en_next;
            oe40_n_reg      <= 1'b1;
            pull125_en_reg  <= pull125_en_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    logic ctl_supply_reg;
    logic ctl_supply_next;
    logic xtal_en_reg;
    logic xtal_en_next;
    logic ext_clk_ok_reg;
    logic ext_clk_ok_next;

    // detector never stops; crystal and external clock stay off, start is on fast osc
    always_comb
    begin
        ctl_supply_next = 1'b1;
        xtal_en_next    = 1'b0;
        ext_clk_ok_next = 1'b0;
    end

    // own flops so these outputs come straight from registers
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctl_supply_reg <= 1'b1;
            xtal_en_reg    <= 1'b0;
            ext_clk_ok_reg <= 1'b0;
        end
        else
        begin
            ctl_supply_reg <= ctl_supply_next;
            xtal_en_reg    <= xtal_en_next;
            ext_clk_ok_reg <= ext_clk_ok_next;
        end
    end

    assign o_internal_reset             = ctl_reset_reg;
    assign o_cpu_clk_en                 = ctl_cpu_clk_reg;
    assign o_fast_internal_osc_en       = ctl_osc_reg;
    assign o_slow_internal_osc_en       = ctl_osc_reg;
    assign o_crystal_osc_en             = xtal_en_reg;
    assign o_osc_pins_input_mode        = oe40_n_reg;
    assign o_external_main_clk_valid    = ext_clk_ok_reg;
    assign o_periph_run                 = ctl_cpu_clk_reg;
    assign o_supply_detect_en           = ctl_supply_reg;
    assign o_pullup_port_pin_pullup_en  = pull40_en_reg;
    assign o_pullup_port_pin_oe_n       = oe40_n_reg;
    assign o_reset_shared_pin_pullup_en = pull125_en_reg;
    assign o_reset_shared_pin_oe_n      = oe40_n_reg;
    assign o_port_oe_n                  = {PORT_COUNT{oe40_n_reg}};
    assign o_pc_valid                   = pc_valid_reg;
    assign o_pc                         = pc_reg;
    assign o_program_status_word        = psw_reg;
    assign o_mem_addr                   = addr_reg;
    assign o_mem_read                   = read_reg;
    assign o_cpu_start                  = start_reg;

endmodule

// ---- rtl/reset_period_defs.svh ----
`ifndef RESET_PERIOD_DEFS_SVH
`define RESET_PERIOD_DEFS_SVH

// reset vector location and preset values
`define RST_VEC_ADDR_LO      20'h00000
`define RST_VEC_ADDR_HI      20'h00001
`define PSW_RESET_VALUE      8'h06
// processing cycles after all sources release
`define RST_PROC_CYCLES      8'h08

`endif

// ---- rtl/reset_period_pkg.sv ----
package reset_period_pkg;

    // sequencer states, gray along the usual path
    typedef enum logic [2:0]
    {
        ST_RESET   = 3'b000,
        ST_PROCESS = 3'b001,
        ST_VEC_LO  = 3'b011,
        ST_VEC_HI  = 3'b010,
        ST_RUN     = 3'b110
    } seq_state_t;

endpackage

// ---- rtl/sync_bus_if.sv ----
`timescale 1ns/1ps

// synchronised reset source levels, from the input stage to the sequencer
interface sync_bus_if #(parameter int WIDTH = 6);
    logic [WIDTH-1:0] level;
    modport producer (output level);
    modport consumer (input level);
endinterface

// ---- rtl/source_sync.sv ----
`timescale 1ns/1ps

module source_sync
#(
    parameter int WIDTH = 6
)
(
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    sync_bus_if.producer          sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // ------------------------------------------------------------
    // three-stage synchroniser, change taken when stages 2 and 3 agree
    // ------------------------------------------------------------
    always_comb
    begin
        level_next = level_reg;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (stage2_reg[i] == stage3_reg[i])
            begin
                level_next[i] = stage3_reg[i];
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg  <= '0;
        end
        else
        begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= level_next;
        end
    end

    assign sync_out.level = level_reg;

endmodule

// ---- bench/reset_period_assertions.sv ----
`timescale 1ns/1ps

module reset_period_assertions
#(
    parameter int PC_WIDTH   = 20,
    parameter int PORT_COUNT = 8
)
(
    input wire logic                  i_clock,
    input wire logic                  i_rst,
    input wire logic                  i_ext_reset_n,
    input wire logic                  i_wdt_reset,
    input wire logic                  i_retention_reset,
    input wire logic [PC_WIDTH-1:0]   o_mem_addr,
    input wire logic                  o_mem_read,
    input wire logic                  o_internal_reset,
    input wire logic                  o_cpu_clk_en,
    input wire logic                  o_fast_internal_osc_en,
    input wire logic                  o_slow_internal_osc_en,
    input wire logic                  o_crystal_osc_en,
    input wire logic                  o_osc_pins_input_mode,
    input wire logic                  o_external_main_clk_valid,
    input wire logic                  o_periph_run,
    input wire logic                  o_supply_detect_en,
    input wire logic                  o_pullup_port_pin_pullup_en,
    input wire logic                  o_pullup_port_pin_oe_n,
    input wire logic                  o_reset_shared_pin_pullup_en,
    input wire logic                  o_reset_shared_pin_oe_n,
    input wire logic [PORT_COUNT-1:0] o_port_oe_n,
    input wire logic                  o_pc_valid,
    input wire logic [7:0]            o_program_status_word,
    input wire logic                  o_cpu_start
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // ----------------------------------------
    // vector fetch steps
    // ----------------------------------------
    sequence s_fetch_lo;
        o_mem_read && (o_mem_addr == '0);
    endsequence
    sequence s_fetch_hi;
        o_mem_read && (o_mem_addr == PC_WIDTH'(1));
    endsequence

    property p_clock_stop;
        i_wdt_reset [*6] |-> !o_fast_internal_osc_en && !o_slow_internal_osc_en && !o_cpu_clk_en;
    endproperty
    property p_crystal_off;
        o_internal_reset |-> !o_crystal_osc_en && o_osc_pins_input_mode;
    endproperty
    property p_ext_clk_off;
        o_internal_reset |-> !o_external_main_clk_valid;
    endproperty
    property p_periph_stop;
        o_internal_reset |-> !o_periph_run && o_supply_detect_en && !o_pc_valid;
    endproperty
    property p_pin_float;
        (!i_ext_reset_n || i_retention_reset) [*6]
            |-> !o_pullup_port_pin_pullup_en && o_pullup_port_pin_oe_n;
    endproperty
    property p_shared_low;
        !i_ext_reset_n [*6] |-> !o_reset_shared_pin_pullup_en && o_reset_shared_pin_oe_n;
    endproperty
    property p_pull_high;
        (i_ext_reset_n && !i_retention_reset) [*6]
            |-> o_pullup_port_pin_pullup_en && o_reset_shared_pin_pullup_en;
    endproperty
    property p_vector_load;
        s_fetch_lo |=> s_fetch_hi ##2 (o_cpu_start && o_pc_valid && o_cpu_clk_en);
    endproperty
    property p_start_state;
        o_cpu_start |-> o_fast_internal_osc_en && (o_program_status_word == 8'h06);
    endproperty
    property p_ports_float;
        &o_port_oe_n;
    endproperty
    property p_merged;
        i_wdt_reset [*6] |-> o_internal_reset;
    endproperty
    property p_process_len;
        $fell(o_internal_reset) ##1 (!o_internal_reset) [*7] |-> s_fetch_lo;
    endproperty

    a_clock_stop:  assert property (p_clock_stop)  else $error("clock not stopped");
    a_crystal_off: assert property (p_crystal_off) else $error("crystal active");
    a_ext_clk_off: assert property (p_ext_clk_off) else $error("ext clock valid");
    a_periph_stop: assert property (p_periph_stop) else $error("periph running");
    a_pin_float:   assert property (p_pin_float)   else $error("pullup pin driven");
    a_shared_low:  assert property (p_shared_low)  else $error("shared pin pulled");
    a_pull_high:   assert property (p_pull_high)   else $error("pull-up missing");
    a_vector_load: assert property (p_vector_load) else $error("fetch order");
    a_start_state: assert property (p_start_state) else $error("start state");
    a_ports_float: assert property (p_ports_float) else $error("port driven");
    a_merged:      assert property (p_merged)      else $error("reset not merged");
    a_process_len: assert property (p_process_len) else $error("process length");
endmodule

bind reset_period_state_control reset_period_assertions #(
    .PC_WIDTH   (PC_WIDTH),
    .PORT_COUNT (PORT_COUNT)
) chk_u (.*);

// ---- bench/vector_rom_model.sv ----
`timescale 1ns/1ps

module vector_rom_model
#(
    parameter logic [15:0] VECTOR = 16'hA53C,
    parameter int          AW     = 20
)
(
    input  wire logic          i_clock,
    input  wire logic          i_read,
    input  wire logic [AW-1:0] i_addr,
    output logic      [7:0]    o_data
);
    logic [7:0] data_reg = 8'h5A;

    // one-cycle read latency; between reads the bus toggles
    always_ff @(posedge i_clock)
    begin
        if (i_read)
            data_reg <= i_addr[0] ? VECTOR[15:8] : VECTOR[7:0];
        else
            data_reg <= ~data_reg;
    end
    assign o_data = data_reg;
endmodule

// ---- bench/test_reset_period_state_control.sv ----
`timescale 1ns/1ps

module test_reset_period_state_control;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [5:0] src = 6'h00;
    logic i_ext_reset_n, i_wdt_reset, i_illegal_instr_reset, i_illegal_access_reset;
    logic i_supply_reset, i_retention_reset, o_mem_read, o_internal_reset, o_cpu_clk_en;
    logic o_fast_internal_osc_en, o_slow_internal_osc_en, o_crystal_osc_en, o_periph_run;
    logic o_osc_pins_input_mode, o_external_main_clk_valid, o_supply_detect_en, o_pc_valid;
    logic o_pullup_port_pin_pullup_en, o_pullup_port_pin_oe_n, o_reset_shared_pin_pullup_en;
    logic o_reset_shared_pin_oe_n, o_cpu_start;
    logic [7:0] i_mem_rdata, o_program_status_word, o_port_oe_n;
    logic [19:0] o_mem_addr, o_pc;
    int bad_count = 0;
    int n_tests = 0;

    // ----------------------------------------
    // clock, sources, design and vector memory
    // ----------------------------------------
    always #5 i_clock = ~i_clock;
    assign i_ext_reset_n = ~src[0];
    assign {i_retention_reset, i_supply_reset, i_illegal_access_reset} = src[5:3];
    assign {i_illegal_instr_reset, i_wdt_reset} = src[2:1];
    reset_period_state_control dut_u (.*);
    vector_rom_model rom_u (.i_clock(i_clock), .i_read(o_mem_read), .i_addr(o_mem_addr),
                            .o_data(i_mem_rdata));

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bounded wait for start, then state after release
    task automatic boot_check();
        int n;
        for (n = 0; n < 60 && o_cpu_start !== 1'b1; n++)
            @(negedge i_clock);
        chk_bit("start", 1'b1, o_cpu_start);
        if (o_cpu_start !== 1'b1)
            results();
        else
        begin
            chk_word("pc", 20'h0A53C, o_pc);
            chk_word("fetch addr", 20'h00001, o_mem_addr);
            chk_word("psw", 20'h00006, {12'h000, o_program_status_word});
            chk_bit("clk_en", 1'b1, o_cpu_clk_en && o_periph_run);
            chk_bit("fast osc", 1'b1, o_fast_internal_osc_en);
            chk_bit("pullups", 1'b1, o_pullup_port_pin_pullup_en & o_reset_shared_pin_pullup_en);
            chk_word("port oe_n", 20'h000FF, {12'h000, o_port_oe_n});
            chk_bit("pc valid run", 1'b1, o_pc_valid);
            chk_bit("int reset off", 1'b0, o_internal_reset);
        end
    endtask

    // each source alone: reset-period pin and clock states
    task automatic t_each_source();
        int k;
        for (k = 0; k < 6; k++)
        begin
            src = 6'h01 << k;
            repeat (10) @(negedge i_clock);
            chk_bit("int reset", 1'b1, o_internal_reset);
            chk_bit("osc off", 1'b0, o_fast_internal_osc_en | o_slow_internal_osc_en);
            chk_bit("crystal", 1'b0, o_crystal_osc_en);
            chk_bit("osc pins in", 1'b1, o_osc_pins_input_mode);
            chk_bit("pin oe_n", 1'b1, o_pullup_port_pin_oe_n & o_reset_shared_pin_oe_n);
            chk_bit("ext clk", 1'b0, o_external_main_clk_valid);
            chk_bit("periph", 1'b0, o_periph_run);
            chk_bit("supply det", 1'b1, o_supply_detect_en);
            chk_bit("pc valid", 1'b0, o_pc_valid);
            chk_bit("pullup pin", k != 0 && k != 5, o_pullup_port_pin_pullup_en);
            chk_bit("shared pin", k != 0, o_reset_shared_pin_pullup_en);
            src = 6'h00;
            boot_check();
        end
    endtask

    // reassertion during processing restarts the sequence
    task automatic t_abort();
        int n;
        src = 6'h02;
        repeat (10) @(negedge i_clock);
        src = 6'h00;
        repeat (8) @(negedge i_clock);
        src = 6'h08;
        for (n = 0; n < 20; n++)
        begin
            @(negedge i_clock);
            chk_bit("no fetch", 1'b0, o_mem_read | o_cpu_start);
        end
        src = 6'h00;
        boot_check();
    endtask

    // overlapping sources keep the merged reset up
    task automatic t_overlap();
        src = 6'h12;
        repeat (10) @(negedge i_clock);
        src = 6'h10;
        repeat (12) @(negedge i_clock);
        chk_bit("held", 1'b1, o_internal_reset);
        chk_bit("pc undefined", 1'b0, o_pc_valid);
        src = 6'h00;
        boot_check();
    endtask

    initial
    begin
        repeat (5) @(negedge i_clock);
        i_rst = 1'b0;
        boot_check();
        t_each_source();
        t_abort();
        t_overlap();
        i_rst = 1'b1;
        repeat (5) @(negedge i_clock);
        i_rst = 1'b0;
        boot_check();
        results();
    end
endmodule
